// File: src/csm_pkg.sv
// cpu status, multiply/divide and pointer block: shared constants and types
// assumes one core clock and a synchronous active-high reset

package csm_pkg;

	// special register addresses
	localparam logic [7:0] ADR_PTR0_LO   = 8'h82;
	localparam logic [7:0] ADR_PTR0_HI   = 8'h83;
	localparam logic [7:0] ADR_PTR1_LO   = 8'h84;
	localparam logic [7:0] ADR_PTR1_HI   = 8'h85;
	localparam logic [7:0] ADR_MODE      = 8'h86;
	localparam logic [7:0] ADR_STATUS    = 8'hd0;
	localparam logic [7:0] ADR_ACC       = 8'he0;
	localparam logic [7:0] ADR_OPND_B    = 8'hf0;
	localparam logic [7:0] ADR_EXT_ACC   = 8'hf1;
	localparam logic [7:0] LOWER_RAM_TOP = 8'h7f;

	// program_status_word bit positions
	localparam int BIT_CARRY  = 7;
	localparam int BIT_HALF   = 6;
	localparam int BIT_USER_A = 5;
	localparam int BIT_BANK_H = 4;
	localparam int BIT_BANK_L = 3;
	localparam int BIT_SIGN   = 2;
	localparam int BIT_USER_B = 1;
	localparam int BIT_ODD    = 0;

	// instruction_mode_control bit positions
	localparam int BIT_PTR_SEL   = 0;
	localparam int BIT_WIDE_PROD = 2;
	localparam int BIT_WIDE_QUOT = 3;

	localparam logic [7:0] MODE_WR_MASK   = 8'h0d;
	localparam logic [7:0] STATUS_WR_MASK = 8'hfe;
	localparam logic [7:0] RST_BYTE       = 8'h00;
	localparam logic [15:0] RST_PTR       = 16'h0000;

	typedef enum logic [2:0] {
		csm_op_add,
		csm_op_addc,
		csm_op_subb,
		csm_op_and,
		csm_op_or,
		csm_op_xor,
		csm_op_product,
		csm_op_quotient
	} csm_op_type;

endpackage

// File: src/csm_muldiv.sv
// multiply/divide unit, purely combinational
// assumes the caller registers the results and owns the flags

`timescale 1ns/1ns
`default_nettype none

module csm_muldiv (
	input  wire logic [7:0] acc_in,
	input  wire logic [7:0] opnd_b_in,
	input  wire logic [7:0] ext_in,
	input  wire logic       wide_prod,
	input  wire logic       wide_quot,
	input  wire logic       is_quot,
	output logic      [7:0] acc_out,
	output logic      [7:0] opnd_b_out,
	output logic      [7:0] ext_out,
	output logic            sign_err
);

	logic [23:0] prod;
	logic [15:0] dvd;
	logic [15:0] quot;
	logic [15:0] rem;

	always_comb begin
		prod = {8'h00, (wide_prod ? ext_in : 8'h00), acc_in} * {16'h0000, opnd_b_in};
		dvd  = {(wide_quot ? ext_in : 8'h00), acc_in};
		quot = 16'h0000;
		rem  = 16'h0000;
		if (opnd_b_in != 8'h00) begin
			quot = dvd / {8'h00, opnd_b_in};
			rem  = dvd % {8'h00, opnd_b_in};
		end
		if (!is_quot) begin
			acc_out    = prod[7:0];
			opnd_b_out = prod[15:8];
			ext_out    = wide_prod ? prod[23:16] : ext_in;
			sign_err   = wide_prod ? (prod[23:16] != 8'h00) : (prod[15:8] != 8'h00);
		end else if (opnd_b_in == 8'h00) begin
			// zero divisor leaves the operands untouched
			acc_out    = acc_in;
			opnd_b_out = opnd_b_in;
			ext_out    = ext_in;
			sign_err   = 1'b1;
		end else begin
			acc_out    = quot[7:0];
			opnd_b_out = rem[7:0];
			ext_out    = wide_quot ? quot[15:8] : ext_in;
			sign_err   = 1'b0;
		end
	end

endmodule

`default_nettype wire

// File: src/csm_iram.sv
// 256-byte internal data ram, one port, registered read
// assumes the core has already resolved direct versus indirect routing

`timescale 1ns/1ns
`default_nettype none

module csm_iram import csm_pkg::*; (
	input  wire logic       core_clk,
	input  wire logic       reset,
	input  wire logic [7:0] addr,
	input  wire logic       wr,
	input  wire logic       rd,
	input  wire logic [7:0] wdata,
	output logic      [7:0] rdata_ff
);

	logic [7:0] mem [0:255];

	// contents are not cleared by reset, only the read latch
	always_ff @(posedge core_clk) begin
		if (wr) begin
			mem[addr] <= wdata;
		end
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			rdata_ff <= RST_BYTE;
		end else if (rd) begin
			rdata_ff <= mem[addr];
		end
	end

endmodule

`default_nettype wire

// File: src/csm_core.sv
// cpu core status word, accumulators, multiply/divide, dual pointers, data space decode
// assumes the sequencer issues at most one operation and one data access per cycle
//
// Behaviour
// - carry_flag bit 7 follows carry or borrow of add and subtract.
// - half_carry_flag bit 6 follows nibble carry or borrow.
// - status bits 5 and 1 are free user flags.
// - bank_select_field bits 4-3 place R0-R7 at 00H, 08H, 10H or 18H.
// - arith_sign_error_flag bit 2 is 1 on overflow or zero divisor, else 0; logic ops leave it unchanged.
// - bit 0 is read-only, 1 when accumulator has odd ones.
// - whole status word resets to zero on every reset.
// - primary pointer is 16 bits, reachable whole or as two bytes.
// - a second identical pointer sits beside the primary one.
// - pointer_choice_bit picks primary at 0, second at 1, for pointer use.
// - after reset multiply and divide run in 8-bit form.
// - narrow multiply: A times B, low to A, high to B.
// - wide multiply: ext:A times B, bytes to A, B, ext.
// - narrow divide: A over B, quotient A, remainder B.
// - wide divide: ext:A over B, quotient low A, remainder B, high ext.
// - extension accumulator is a scratch register otherwise.
// - lower ram 00H-7FH reachable directly and indirectly.
// - upper ram 80H-FFH reachable only indirectly.
// - special registers 80H-FFH reachable only directly.
// - above 7FH, addressing mode chooses ram or special registers.
// - unassigned special addresses hold no storage.
// - second operand register joins multiply/divide, otherwise scratch.

`timescale 1ns/1ns
`default_nettype none

module csm_core import csm_pkg::*; (
	input  wire logic        core_clk,
	input  wire logic        reset,
	input  wire logic        op_valid,
	input  wire csm_op_type  op_code,
	input  wire logic [7:0]  op_operand,
	input  wire logic [7:0]  mem_addr,
	input  wire logic        mem_indirect,
	input  wire logic        mem_wr,
	input  wire logic        mem_rd,
	input  wire logic [7:0]  mem_wdata,
	output logic      [7:0]  mem_rdata,
	output logic             mem_unmapped,
	input  wire logic        ptr_load,
	input  wire logic [15:0] ptr_load_value,
	input  wire logic        ptr_inc,
	output logic      [15:0] ptr_value,
	output logic      [7:0]  acc_value,
	output logic      [7:0]  program_status_word,
	output logic      [7:0]  bank_base
);

	////////////////////////////////////////////////////////////////////////////

	logic [7:0]  acc_ff;
	logic [7:0]  opnd_b_ff;
	logic [7:0]  ext_ff;
	logic [7:0]  status_ff;
	logic [7:0]  mode_ff;
	logic [15:0] ptr0_ff;
	logic [15:0] ptr1_ff;
	logic [7:0]  sfr_rdata_ff;
	logic        rd_sfr_ff;
	logic        unmapped_ff;
	logic [7:0]  ram_rdata;

	logic        sfr_path;
	logic        ram_path;
	logic        wr_sfr;
	logic        is_md;
	logic        pointer_choice_bit;
	logic [7:0]  md_acc;
	logic [7:0]  md_opnd_b;
	logic [7:0]  md_ext;
	logic        md_sign_err;
	logic [7:0]  alu_res;
	logic        alu_carry;
	logic        alu_half;
	logic        alu_sign;
	logic        cin;
	logic [8:0]  sum9;
	logic [4:0]  nib5;
	logic [7:0]  sfr_rd_val;

	function automatic logic sfr_known(input logic [7:0] a);
		return (a == ADR_PTR0_LO) || (a == ADR_PTR0_HI) || (a == ADR_PTR1_LO) ||
			(a == ADR_PTR1_HI) || (a == ADR_MODE) || (a == ADR_STATUS) ||
			(a == ADR_ACC) || (a == ADR_OPND_B) || (a == ADR_EXT_ACC);
	endfunction

	// pointer update shared by both pointers; whole-word moves beat byte writes
	function automatic logic [15:0] ptr_next(
		input logic [15:0] cur,
		input logic        mine,
		input logic        wr,
		input logic [7:0]  a,
		input logic [7:0]  lo_adr,
		input logic [7:0]  hi_adr
	);
		logic [15:0] r;
		r = cur;
		if (mine && ptr_load) begin
			r = ptr_load_value;
		end else if (mine && ptr_inc) begin
			r = cur + 16'h0001;
		end else if (wr && a == lo_adr) begin
			r = {cur[15:8], mem_wdata};
		end else if (wr && a == hi_adr) begin
			r = {mem_wdata, cur[7:0]};
		end
		return r;
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// data space routing

	assign sfr_path = !mem_indirect && (mem_addr > LOWER_RAM_TOP);
	assign ram_path = mem_indirect || (mem_addr <= LOWER_RAM_TOP);
	assign wr_sfr   = mem_wr && sfr_path;

	csm_iram u_iram (
		.core_clk (core_clk),
		.reset    (reset),
		.addr     (mem_addr),
		.wr       (mem_wr && ram_path),
		.rd       (mem_rd && ram_path),
		.wdata    (mem_wdata),
		.rdata_ff (ram_rdata)
	);

	always_comb begin
		case (mem_addr)
			ADR_PTR0_LO: sfr_rd_val = ptr0_ff[7:0];
			ADR_PTR0_HI: sfr_rd_val = ptr0_ff[15:8];
			ADR_PTR1_LO: sfr_rd_val = ptr1_ff[7:0];
			ADR_PTR1_HI: sfr_rd_val = ptr1_ff[15:8];
			ADR_MODE:    sfr_rd_val = mode_ff;
			ADR_STATUS:  sfr_rd_val = program_status_word;
			ADR_ACC:     sfr_rd_val = acc_ff;
			ADR_OPND_B:  sfr_rd_val = opnd_b_ff;
			ADR_EXT_ACC: sfr_rd_val = ext_ff;
			default:     sfr_rd_val = 8'h00;
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			sfr_rdata_ff <= RST_BYTE;
			rd_sfr_ff    <= 1'b0;
			unmapped_ff  <= 1'b0;
		end else begin
			if (mem_rd && sfr_path) begin
				sfr_rdata_ff <= sfr_rd_val;
			end
			if (mem_rd) begin
				rd_sfr_ff   <= sfr_path;
				unmapped_ff <= sfr_path && !sfr_known(mem_addr);
			end
		end
	end

	assign mem_rdata    = rd_sfr_ff ? sfr_rdata_ff : ram_rdata;
	assign mem_unmapped = unmapped_ff;

	////////////////////////////////////////////////////////////////////////////
	// arithmetic

	assign is_md = (op_code == csm_op_product) || (op_code == csm_op_quotient);

	csm_muldiv u_muldiv (
		.acc_in     (acc_ff),
		.opnd_b_in  (opnd_b_ff),
		.ext_in     (ext_ff),
		.wide_prod  (mode_ff[BIT_WIDE_PROD]),
		.wide_quot  (mode_ff[BIT_WIDE_QUOT]),
		.is_quot    (op_code == csm_op_quotient),
		.acc_out    (md_acc),
		.opnd_b_out (md_opnd_b),
		.ext_out    (md_ext),
		.sign_err   (md_sign_err)
	);

	// logic ops raise no carry and leave the flags as they were
	always_comb begin
		alu_res   = acc_ff;
		alu_carry = status_ff[BIT_CARRY];
		alu_half  = status_ff[BIT_HALF];
		alu_sign  = status_ff[BIT_SIGN];
		cin       = (op_code != csm_op_add) && status_ff[BIT_CARRY];
		sum9      = 9'h000;
		nib5      = 5'h00;
		unique case (op_code)
			csm_op_add, csm_op_addc: begin
				sum9      = {1'b0, acc_ff} + {1'b0, op_operand} + {8'h00, cin};
				nib5      = {1'b0, acc_ff[3:0]} + {1'b0, op_operand[3:0]} + {4'h0, cin};
				alu_res   = sum9[7:0];
				alu_carry = sum9[8];
				alu_half  = nib5[4];
				alu_sign  = (acc_ff[7] == op_operand[7]) && (sum9[7] != acc_ff[7]);
			end
			csm_op_subb: begin
				sum9      = {1'b0, acc_ff} - {1'b0, op_operand} - {8'h00, cin};
				nib5      = {1'b0, acc_ff[3:0]} - {1'b0, op_operand[3:0]} - {4'h0, cin};
				alu_res   = sum9[7:0];
				alu_carry = sum9[8];
				alu_half  = nib5[4];
				alu_sign  = (acc_ff[7] != op_operand[7]) && (sum9[7] != acc_ff[7]);
			end
			csm_op_and: alu_res = acc_ff & op_operand;
			csm_op_or:  alu_res = acc_ff | op_operand;
			csm_op_xor: alu_res = acc_ff ^ op_operand;
			csm_op_product, csm_op_quotient: begin
				alu_res   = md_acc;
				alu_carry = 1'b0;
				alu_sign  = md_sign_err;
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////////////
	// accumulator, second operand, extension accumulator
	// an operation beats a register write to the same target in one cycle

	always_ff @(posedge core_clk) begin
		if (reset) begin
			acc_ff <= RST_BYTE;
		end else if (op_valid) begin
			acc_ff <= alu_res;
		end else if (wr_sfr && mem_addr == ADR_ACC) begin
			acc_ff <= mem_wdata;
		end
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			opnd_b_ff <= RST_BYTE;
		end else if (op_valid && is_md) begin
			opnd_b_ff <= md_opnd_b;
		end else if (wr_sfr && mem_addr == ADR_OPND_B) begin
			opnd_b_ff <= mem_wdata;
		end
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			ext_ff <= RST_BYTE;
		end else if (op_valid && is_md) begin
			ext_ff <= md_ext;
		end else if (wr_sfr && mem_addr == ADR_EXT_ACC) begin
			ext_ff <= mem_wdata;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// status word and mode register

	always_ff @(posedge core_clk) begin
		if (reset) begin
			status_ff <= RST_BYTE;
		end else if (op_valid) begin
			status_ff[BIT_CARRY] <= alu_carry;
			status_ff[BIT_HALF]  <= alu_half;
			status_ff[BIT_SIGN]  <= alu_sign;
		end else if (wr_sfr && mem_addr == ADR_STATUS) begin
			status_ff <= mem_wdata & STATUS_WR_MASK;
		end
	end

	// parity is never stored, so it cannot lag the accumulator
	assign program_status_word = {status_ff[7:1], ^acc_ff};
	assign bank_base = {3'h0, status_ff[BIT_BANK_H:BIT_BANK_L], 3'h0};

	always_ff @(posedge core_clk) begin
		if (reset) begin
			mode_ff <= RST_BYTE;
		end else if (wr_sfr && mem_addr == ADR_MODE) begin
			mode_ff <= mem_wdata & MODE_WR_MASK;
		end
	end

	assign pointer_choice_bit = mode_ff[BIT_PTR_SEL];
	assign acc_value = acc_ff;

	////////////////////////////////////////////////////////////////////////////
	// dual pointers

	always_ff @(posedge core_clk) begin
		if (reset) begin
			ptr0_ff <= RST_PTR;
		end else begin
			ptr0_ff <= ptr_next(ptr0_ff, !pointer_choice_bit, wr_sfr, mem_addr,
				ADR_PTR0_LO, ADR_PTR0_HI);
		end
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			ptr1_ff <= RST_PTR;
		end else begin
			ptr1_ff <= ptr_next(ptr1_ff, pointer_choice_bit, wr_sfr, mem_addr,
				ADR_PTR1_LO, ADR_PTR1_HI);
		end
	end

	assign ptr_value = pointer_choice_bit ? ptr1_ff : ptr0_ff;

	////////////////////////////////////////////////////////////////////////////
	// checks

	logic [3:0]  acc_nib;
	logic [3:0]  opr_nib;
	logic [15:0] wide_dvd;
	logic        wr_status;
	assign acc_nib   = acc_ff[3:0];
	assign opr_nib   = op_operand[3:0];
	assign wide_dvd  = {ext_ff, acc_ff};
	assign wr_status = wr_sfr && mem_addr == ADR_STATUS && !op_valid;

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (reset);

	sequence s_wide_quot_issue;
		op_valid && op_code == csm_op_quotient && mode_ff[BIT_WIDE_QUOT] && opnd_b_ff != 8'h00;
	endsequence
	sequence s_wide_prod_issue;
		op_valid && op_code == csm_op_product && mode_ff[BIT_WIDE_PROD];
	endsequence

	property p_add_carry;
		op_valid && op_code == csm_op_add |=> program_status_word[BIT_CARRY] ==
			(({1'b0, $past(acc_ff)} + {1'b0, $past(op_operand)}) > 9'h0ff);
	endproperty
	a_add_carry: assert property (p_add_carry) else $error("carry wrong after add");

	property p_add_half;
		op_valid && op_code == csm_op_add |=> program_status_word[BIT_HALF] ==
			(({1'b0, $past(acc_nib)} + {1'b0, $past(opr_nib)}) > 5'h0f);
	endproperty
	a_add_half: assert property (p_add_half) else $error("half carry wrong after add");

	property p_user_bank;
		wr_status |=> program_status_word[BIT_USER_A] == $past(mem_wdata[BIT_USER_A]) &&
			bank_base == {3'h0, $past(mem_wdata[BIT_BANK_H:BIT_BANK_L]), 3'h0};
	endproperty
	a_user_bank: assert property (p_user_bank) else $error("user flag or bank wrong");

	property p_quot_zero;
		op_valid && op_code == csm_op_quotient && opnd_b_ff == 8'h00 |=>
			program_status_word[BIT_SIGN] && !program_status_word[BIT_CARRY];
	endproperty
	a_quot_zero: assert property (p_quot_zero) else $error("zero divisor not flagged");

	property p_odd_ones;
		wr_sfr && mem_addr == ADR_ACC && !op_valid |=>
			program_status_word[BIT_ODD] == ^$past(mem_wdata);
	endproperty
	a_odd_ones: assert property (p_odd_ones) else $error("odd-ones flag wrong");

	property p_reset_clear;
		$fell(reset) |-> program_status_word[7:1] == 7'h00 && mode_ff == 8'h00;
	endproperty
	a_reset_clear: assert property (p_reset_clear) else $error("state not cleared");

	property p_ptr_load;
		ptr_load && !(wr_sfr && mem_addr == ADR_MODE) |=> ptr_value == $past(ptr_load_value);
	endproperty
	a_ptr_load: assert property (p_ptr_load) else $error("selected pointer not loaded");

	property p_other_ptr_kept;
		ptr_load && !pointer_choice_bit && !wr_sfr |=> $stable(ptr1_ff);
	endproperty
	a_other_ptr_kept: assert property (p_other_ptr_kept) else $error("idle pointer moved");

	property p_narrow_prod;
		op_valid && op_code == csm_op_product && !mode_ff[BIT_WIDE_PROD] |=>
			{opnd_b_ff, acc_ff} == {8'h00, $past(acc_ff)} * {8'h00, $past(opnd_b_ff)};
	endproperty
	a_narrow_prod: assert property (p_narrow_prod) else $error("narrow product wrong");

	property p_wide_prod;
		s_wide_prod_issue |=> {ext_ff, opnd_b_ff, acc_ff} ==
			{8'h00, $past(wide_dvd)} * {16'h0000, $past(opnd_b_ff)};
	endproperty
	a_wide_prod: assert property (p_wide_prod) else $error("wide product wrong");

	property p_wide_quot;
		s_wide_quot_issue |=> {ext_ff, acc_ff} == $past(wide_dvd) / {8'h00, $past(opnd_b_ff)} &&
			{8'h00, opnd_b_ff} == $past(wide_dvd) % {8'h00, $past(opnd_b_ff)};
	endproperty
	a_wide_quot: assert property (p_wide_quot) else $error("wide quotient wrong");

	property p_unmapped;
		mem_rd && sfr_path && !sfr_known(mem_addr) |=> mem_unmapped && mem_rdata == 8'h00;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unassigned address answered");

endmodule

`default_nettype wire

// File: bench/tb_cpu_status_muldiv_pointers.sv
// self-checking bench for the cpu status, multiply/divide and pointer core
// assumes csm_core alone, driven 1 ns after each rising core_clk edge

`timescale 1ns/1ns
`default_nettype none

module tb_cpu_status_muldiv_pointers import csm_pkg::*; ();

	logic        core_clk;
	logic        reset;
	logic        op_valid;
	csm_op_type  op_code;
	logic [7:0]  op_operand;
	logic [7:0]  mem_addr;
	logic        mem_indirect;
	logic        mem_wr;
	logic        mem_rd;
	logic [7:0]  mem_wdata;
	logic [7:0]  mem_rdata;
	logic        mem_unmapped;
	logic        ptr_load;
	logic [15:0] ptr_load_value;
	logic        ptr_inc;
	logic [15:0] ptr_value;
	logic [7:0]  acc_value;
	logic [7:0]  program_status_word;
	logic [7:0]  bank_base;
	int          err_count;
	int          comparisons;

	////////////////////////////////////////////////////////////////////////////////

	csm_core dut_u (
		.core_clk            (core_clk),
		.reset               (reset),
		.op_valid            (op_valid),
		.op_code             (op_code),
		.op_operand          (op_operand),
		.mem_addr            (mem_addr),
		.mem_indirect        (mem_indirect),
		.mem_wr              (mem_wr),
		.mem_rd              (mem_rd),
		.mem_wdata           (mem_wdata),
		.mem_rdata           (mem_rdata),
		.mem_unmapped        (mem_unmapped),
		.ptr_load            (ptr_load),
		.ptr_load_value      (ptr_load_value),
		.ptr_inc             (ptr_inc),
		.ptr_value           (ptr_value),
		.acc_value           (acc_value),
		.program_status_word (program_status_word),
		.bank_base           (bank_base)
	);

	always #4 core_clk = ~core_clk;

	////////////////////////////////////////////////////////////////////////////////

	task automatic step();
		@(posedge core_clk);
		#1;
	endtask

	task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		comparisons++;
		if (seen !== exp) begin
			err_count++;
			$display("Error %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic report_and_stop();
		if (err_count == 0 && comparisons > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	// strobes drop and an idle edge follows, so no signal is set twice per step
	task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic ind);
		mem_addr = a;
		mem_wdata = d;
		mem_indirect = ind;
		mem_wr = 1'b1;
		step();
		mem_wr = 1'b0;
		step();
	endtask

	task automatic rd(input logic [7:0] a, input logic ind, input logic [7:0] exp,
		input logic unm);
		mem_addr = a;
		mem_indirect = ind;
		mem_rd = 1'b1;
		step();
		mem_rd = 1'b0;
		check("mem_rdata", {8'h00, mem_rdata}, {8'h00, exp});
		check("mem_unmapped", {15'h0000, mem_unmapped}, {15'h0000, unm});
		step();
	endtask

	task automatic op(input csm_op_type c, input logic [7:0] o, input logic [7:0] ea,
		input logic [7:0] ep);
		op_code = c;
		op_operand = o;
		op_valid = 1'b1;
		step();
		op_valid = 1'b0;
		check("acc_value", {8'h00, acc_value}, {8'h00, ea});
		check("program_status_word", {8'h00, program_status_word}, {8'h00, ep});
		step();
	endtask

	task automatic ptr(input logic ld, input logic inc, input logic [15:0] v,
		input logic [15:0] exp);
		ptr_load = ld;
		ptr_inc = inc;
		ptr_load_value = v;
		step();
		ptr_load = 1'b0;
		ptr_inc = 1'b0;
		check("ptr_value", ptr_value, exp);
		step();
	endtask

	task automatic do_reset();
		reset = 1'b1;
		repeat (5) step();
		reset = 1'b0;
	endtask

	////////////////////////////////////////////////////////////////////////////////

	// no handshake waits here, so one bounded guard covers a hang
	initial begin
		repeat (3000) @(posedge core_clk);
		err_count++;
		report_and_stop();
	end

	initial begin
		core_clk = 1'b0;
		reset = 1'b1;
		op_valid = 1'b0;
		op_code = csm_op_add;
		op_operand = 8'h00;
		mem_addr = 8'h00;
		mem_indirect = 1'b0;
		mem_wr = 1'b0;
		mem_rd = 1'b0;
		mem_wdata = 8'h00;
		ptr_load = 1'b0;
		ptr_load_value = 16'h0000;
		ptr_inc = 1'b0;
		err_count = 0;
		comparisons = 0;
		#1;
		do_reset();
		rd(8'hd0, 1'b0, 8'h00, 1'b0);
		rd(8'h86, 1'b0, 8'h00, 1'b0);
		for (int i = 0; i < 4; i++) begin
			wr(8'hd0, 8'h23 | 8'(i << 3), 1'b0);
			rd(8'hd0, 1'b0, 8'h22 | 8'(i << 3), 1'b0);
			check("bank_base", {8'h00, bank_base}, 16'(i * 8));
		end
		// parity follows the accumulator, status writes cannot set it
		wr(8'he0, 8'h07, 1'b0);
		check("parity", {15'h0000, program_status_word[0]}, 16'h0001);
		wr(8'he0, 8'h03, 1'b0);
		check("parity", {15'h0000, program_status_word[0]}, 16'h0000);
		wr(8'hd0, 8'h00, 1'b0);
		op(csm_op_add, 8'h7f, 8'h82, 8'h44);
		wr(8'he0, 8'h7f, 1'b0);
		op(csm_op_add, 8'h01, 8'h80, 8'h45);
		wr(8'he0, 8'hff, 1'b0);
		op(csm_op_add, 8'h01, 8'h00, 8'hc0);
		op(csm_op_subb, 8'h01, 8'hfe, 8'hc1);
		op(csm_op_addc, 8'h01, 8'h00, 8'hc0);
		op(csm_op_xor, 8'hff, 8'hff, 8'hc0);
		op(csm_op_and, 8'h0f, 8'h0f, 8'hc0);
		op(csm_op_or, 8'h30, 8'h3f, 8'hc0);
		// multiply and divide, narrow then wide
		wr(8'hd0, 8'h00, 1'b0);
		wr(8'he0, 8'h20, 1'b0);
		wr(8'hf0, 8'h10, 1'b0);
		op(csm_op_product, 8'h00, 8'h00, 8'h04);
		rd(8'hf0, 1'b0, 8'h02, 1'b0);
		wr(8'h86, 8'h04, 1'b0);
		wr(8'hf1, 8'h12, 1'b0);
		wr(8'he0, 8'h34, 1'b0);
		wr(8'hf0, 8'h10, 1'b0);
		op(csm_op_product, 8'h00, 8'h40, 8'h05);
		rd(8'hf0, 1'b0, 8'h23, 1'b0);
		rd(8'hf1, 1'b0, 8'h01, 1'b0);
		wr(8'h86, 8'h00, 1'b0);
		wr(8'hd0, 8'h80, 1'b0);
		wr(8'he0, 8'h64, 1'b0);
		wr(8'hf0, 8'h07, 1'b0);
		op(csm_op_quotient, 8'h00, 8'h0e, 8'h01);
		rd(8'hf0, 1'b0, 8'h02, 1'b0);
		wr(8'h86, 8'h08, 1'b0);
		wr(8'hf1, 8'h12, 1'b0);
		wr(8'he0, 8'h34, 1'b0);
		wr(8'hf0, 8'h10, 1'b0);
		op(csm_op_quotient, 8'h00, 8'h23, 8'h01);
		rd(8'hf0, 1'b0, 8'h04, 1'b0);
		rd(8'hf1, 1'b0, 8'h01, 1'b0);
		wr(8'he0, 8'h55, 1'b0);
		wr(8'hf0, 8'h00, 1'b0);
		op(csm_op_quotient, 8'h00, 8'h55, 8'h04);
		wr(8'hf1, 8'ha5, 1'b0);
		rd(8'hf1, 1'b0, 8'ha5, 1'b0);
		wr(8'hf0, 8'h5a, 1'b0);
		rd(8'hf0, 1'b0, 8'h5a, 1'b0);
		// pointers: bytes, selection, load and wrap
		wr(8'h86, 8'h00, 1'b0);
		wr(8'h82, 8'h11, 1'b0);
		wr(8'h83, 8'h22, 1'b0);
		check("ptr_value", ptr_value, 16'h2211);
		rd(8'h83, 1'b0, 8'h22, 1'b0);
		wr(8'h86, 8'hff, 1'b0);
		rd(8'h86, 1'b0, 8'h0d, 1'b0);
		check("ptr_value", ptr_value, 16'h0000);
		wr(8'h84, 8'h33, 1'b0);
		wr(8'h85, 8'h44, 1'b0);
		check("ptr_value", ptr_value, 16'h4433);
		ptr(1'b1, 1'b0, 16'hffff, 16'hffff);
		ptr(1'b0, 1'b1, 16'h0000, 16'h0000);
		wr(8'h86, 8'h00, 1'b0);
		check("ptr_value", ptr_value, 16'h2211);
		// primary selected: load and step it, the second pointer must not move
		ptr(1'b1, 1'b0, 16'h1234, 16'h1234);
		ptr(1'b0, 1'b1, 16'h0000, 16'h1235);
		wr(8'h86, 8'h01, 1'b0);
		check("ptr_value", ptr_value, 16'h0000);
		// data space routing by addressing mode
		wr(8'h30, 8'h5a, 1'b0);
		rd(8'h30, 1'b1, 8'h5a, 1'b0);
		wr(8'h90, 8'h3c, 1'b1);
		rd(8'h90, 1'b0, 8'h00, 1'b1);
		rd(8'h90, 1'b1, 8'h3c, 1'b0);
		wr(8'he0, 8'h77, 1'b0);
		wr(8'he0, 8'h99, 1'b1);
		rd(8'he0, 1'b0, 8'h77, 1'b0);
		rd(8'he0, 1'b1, 8'h99, 1'b0);
		// reset in mid-run clears status and mode again
		wr(8'h86, 8'h0d, 1'b0);
		wr(8'hd0, 8'hfe, 1'b0);
		do_reset();
		rd(8'hd0, 1'b0, 8'h00, 1'b0);
		rd(8'h86, 1'b0, 8'h00, 1'b0);
		check("ptr_value", ptr_value, 16'h0000);
		report_and_stop();
	end

endmodule

`default_nettype wire
